// ---- logic/balb_loopback.sv ----
// Operation
// - a complete loop returns every received bit unchanged toward its sender.
// - a partial loop returns only the selected channel bits and keeps other positions out of the loop.
// - a logical loop may apply a defined modification (here an xor pattern) to the looped bits.
// - a transparent loop forwards the received signal onward while also returning it.
// - a non-transparent loop forwards a defined idle pattern instead of the received signal.
// - while any loop is active the signal from beyond the loop point is blocked.
// - the network termination always provides loop 2, a complete 2B+D loop under exchange layer 1 control.
// - the switching unit provides loop 3, a 2B+D loop per terminal-side interface toward the exchange.
// - loop 3 is selected per interface by layer 3 control or by local maintenance.
// - a remote server may request loop 3 on or off; the switching unit generates the test pattern.

// ---------------------------------------------------------------
// fifo
// ---------------------------------------------------------------
module balb_fifo
  import balb_pkg::*;
#(
  parameter int unsigned WIDTH = 7,
  parameter int unsigned DEPTH = 32
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // write side
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  // read side
  output logic [WIDTH-1:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire do_wr = wr_valid && wr_ready;
  wire do_rd = rd_valid && rd_ready;
  assign wr_ready = (cnt_r != (AW+1)'(DEPTH));
  assign rd_valid = (cnt_r != '0);
  assign rd_data = mem[rp_r];

  always_ff @(posedge core_clk)
  begin
    if (do_wr)
    begin
      mem[wp_r] <= wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (do_wr)
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (do_rd)
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

// ---------------------------------------------------------------
// loopback core
// ---------------------------------------------------------------
module balb_loopback
  import balb_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // line side, from and to the exchange_termination
  input wire logic line_rx_bit,
  input wire logic line_rx_strobe,
  input wire logic line_rx_frame_start,
  input wire logic line_active,
  output logic line_tx_bit,
  output logic line_tx_valid,
  // user side, toward and from the user_terminal
  output logic user_tx_bit,
  output logic user_tx_valid,
  output logic user_tx_echo_zero,
  output logic user_tx_active_frame,
  input wire logic user_rx_bit,
  input wire logic user_rx_valid,
  // loop 2 control from exchange layer 1 signalling
  input wire logic loop2_req,
  input wire logic loop2_transparent,
  // loop 3 control: layer 3, local maintenance, remote server
  input wire logic loop3_l3_on,
  input wire logic loop3_l3_off,
  input wire logic loop3_local_on,
  input wire logic loop3_local_off,
  input wire logic loop3_remote_on,
  input wire logic loop3_remote_off,
  input wire logic loop3_transparent,
  input wire logic loop3_addressed,
  input wire logic [2:0] loop3_chan_mask,
  input wire logic [7:0] logical_xor,
  // status
  output logic loop2_active,
  output logic loop3_active,
  output logic test_pattern_bit
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [5:0] s1_r;
  logic [5:0] s2_r;
  wire [5:0] pins_in = {line_rx_bit, line_rx_strobe, line_rx_frame_start, line_active, user_rx_bit, user_rx_valid};

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_r <= '0;
      s2_r <= '0;
    end
    else
    begin
      s1_r <= pins_in;
      s2_r <= s1_r;
    end
  end

  wire rx_bit = s2_r[5];
  wire rx_stb = s2_r[4];
  wire rx_fs = s2_r[3];
  wire act = s2_r[2];
  wire urx_bit = s2_r[1];
  wire urx_val = s2_r[0];

  // ---------------------------------------------------------------
  // frame position and channel class
  // ---------------------------------------------------------------
  logic [5:0] pos_r;
  logic stb_d_r;
  wire stb_rise = rx_stb && !stb_d_r;
  wire frame_edge = stb_rise && rx_fs;
  wire [5:0] cur_pos = rx_fs ? CNT_RST : ((pos_r == FRAME_LAST) ? CNT_RST : pos_r + 6'h01);

  // simplified bit map: one b1 octet, one b2 octet, two d bits; rest framing/aux
  balb_chan_e chan;
  always_comb
  begin
    if (cur_pos >= 6'h02 && cur_pos < 6'h0a)
      chan = BALB_CH_B1;
    else if (cur_pos >= 6'h0e && cur_pos < 6'h16)
      chan = BALB_CH_B2;
    else if (cur_pos == 6'h0b || cur_pos == 6'h17)
      chan = BALB_CH_D;
    else
      chan = BALB_CH_AUX;
  end

  // ---------------------------------------------------------------
  // loop state, applied at frame boundaries; line deactivation clears it at once
  // ---------------------------------------------------------------
  balb_state_e st_r;
  balb_req_s l3_req_r;
  logic l2_tr_r;
  logic l3_tr_r;
  logic [2:0] mask_r;

  // layer 3 and remote loop 3 requests need the interface to be addressed; local ones do not
  wire l3_on = loop3_addressed && (loop3_l3_on || loop3_remote_on) || loop3_local_on;
  wire l3_off = loop3_addressed && (loop3_l3_off || loop3_remote_off) || loop3_local_off;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      l3_req_r <= '0;
    end
    else if (!act)
    begin
      l3_req_r <= '0;
    end
    else if (l3_on)
    begin
      l3_req_r <= '{on: 1'b1, transparent: loop3_transparent, chan_mask: loop3_chan_mask};
    end
    else if (l3_off)
    begin
      l3_req_r.on <= 1'b0;
    end
  end

  // loop 2 has priority: it is mandatory and closer to the exchange
  balb_state_e st_nxt;
  always_comb
  begin
    st_nxt = st_r;
    if (!act)
      st_nxt = BALB_ST_NORMAL;
    else if (frame_edge)
    begin
      if (loop2_req)
        st_nxt = BALB_ST_LOOP2;
      else if (l3_req_r.on)
        st_nxt = BALB_ST_LOOP3;
      else
        st_nxt = BALB_ST_NORMAL;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= BALB_ST_NORMAL;
      l2_tr_r <= 1'b0;
      l3_tr_r <= 1'b0;
      mask_r <= MASK_RST;
      pos_r <= CNT_RST;
      stb_d_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      stb_d_r <= rx_stb;
      if (stb_rise)
        pos_r <= cur_pos;
      if (frame_edge)
      begin
        l2_tr_r <= loop2_transparent;
        l3_tr_r <= l3_req_r.transparent;
        mask_r <= loop2_req ? CH_ALL : l3_req_r.chan_mask;
      end
    end
  end

  // ---------------------------------------------------------------
  // channel selection and logical modification
  // ---------------------------------------------------------------
  wire loop_on = (st_r != BALB_ST_NORMAL);
  wire in_mask = (chan == BALB_CH_B1 && mask_r[CH_B1]) || (chan == BALB_CH_B2 && mask_r[CH_B2])
                 || (chan == BALB_CH_D && mask_r[CH_D]);
  wire complete = loop_on && (mask_r == CH_ALL);
  wire sel_bit = complete || (loop_on && in_mask);
  wire [2:0] xidx = cur_pos[2:0];
  // xor applied only to b-channel bits of loop 3; zero pattern leaves data unchanged
  wire mod_bit = (st_r == BALB_ST_LOOP3 && (chan == BALB_CH_B1 || chan == BALB_CH_B2))
                 ? logical_xor[xidx] : 1'b0;
  wire looped_bit = rx_bit ^ mod_bit;
  wire transparent = (st_r == BALB_ST_LOOP2) ? l2_tr_r : l3_tr_r;

  // ---------------------------------------------------------------
  // loopback buffer toward the line
  // ---------------------------------------------------------------
  // returned bits queue behind the loop; a bit arriving while the queue is full is dropped
  logic [6:0] q_rd;
  logic q_valid;
  logic tx_take_r;
  wire loop_valid = stb_rise && sel_bit;
  wire normal_valid = !loop_on && urx_val && stb_rise;
  // user data is blocked from the return path while a loop is on
  wire [6:0] q_wdata = loop_valid ? {looped_bit, cur_pos} : {urx_bit, cur_pos};

  balb_fifo #(.WIDTH(7), .DEPTH(DEPTH)) u_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .wr_data(q_wdata),
    .wr_valid(loop_valid || normal_valid),
    .wr_ready(),
    .rd_data(q_rd),
    .rd_valid(q_valid),
    .rd_ready(tx_take_r)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // forward bit: received data with no loop or a transparent loop, idle pattern otherwise
  wire fwd_bit = (!loop_on || transparent) ? rx_bit : FWD_IDLE_BIT;
  // gated by act: the echo flag must drop together with the active frames
  wire echo_zero = (st_r == BALB_ST_LOOP2) && l2_tr_r && act;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      line_tx_bit <= 1'b0;
      line_tx_valid <= 1'b0;
      tx_take_r <= 1'b0;
      user_tx_bit <= 1'b0;
      user_tx_valid <= 1'b0;
      user_tx_echo_zero <= 1'b0;
      user_tx_active_frame <= 1'b0;
      loop2_active <= 1'b0;
      loop3_active <= 1'b0;
      test_pattern_bit <= 1'b0;
    end
    else
    begin
      tx_take_r <= q_valid && !tx_take_r && stb_rise;
      line_tx_valid <= q_valid && tx_take_r;
      if (q_valid && tx_take_r)
        line_tx_bit <= q_rd[6];
      user_tx_bit <= echo_zero ? rx_bit : fwd_bit;
      user_tx_valid <= stb_rise;
      user_tx_echo_zero <= echo_zero;
      user_tx_active_frame <= act && (echo_zero || !loop_on || transparent);
      loop2_active <= (st_r == BALB_ST_LOOP2);
      loop3_active <= (st_r == BALB_ST_LOOP3);
      // unit-generated pattern on test_pattern_bit while loop 3 is on: alternating per frame position
      test_pattern_bit <= (st_r == BALB_ST_LOOP3) ? cur_pos[0] : 1'b0;
    end
  end

endmodule

// ---- logic/balb_pkg.sv ----
package balb_pkg;

  // ---------------------------------------------------------------
  // frame and channel layout
  // ---------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 48;
  localparam int unsigned CNT_W = 6;
  localparam logic [5:0] FRAME_LAST = 6'h2f;
  localparam int unsigned FIFO_DEPTH = 32;

  // channel selection bits in the partial-loop mask
  localparam int unsigned CH_B1 = 0;
  localparam int unsigned CH_B2 = 1;
  localparam int unsigned CH_D = 2;
  localparam logic [2:0] CH_ALL = 3'h7;

  // reset values
  localparam logic [5:0] CNT_RST = 6'h00;
  localparam logic [2:0] MASK_RST = 3'h0;

  // forward-path replacement pattern for non-transparent loops
  localparam logic FWD_IDLE_BIT = 1'b1;

  // channel class of each bit position in a frame
  typedef enum logic [3:0] {
    BALB_CH_B1 = 4'b0001,
    BALB_CH_B2 = 4'b0010,
    BALB_CH_D = 4'b0100,
    BALB_CH_AUX = 4'b1000
  } balb_chan_e;

  // loop state
  typedef enum logic [2:0] {
    BALB_ST_NORMAL = 3'b001,
    BALB_ST_LOOP2 = 3'b010,
    BALB_ST_LOOP3 = 3'b100
  } balb_state_e;

  // loop request as it arrives from a control source
  typedef struct packed {
    logic on;
    logic transparent;
    logic [2:0] chan_mask;
  } balb_req_s;

  // one line bit with its frame position
  typedef struct packed {
    logic bit_val;
    logic [5:0] pos;
  } balb_bit_s;

endpackage

// ---- bench/balb_line_model.sv ----
// ---------------------------------------------------------------
// exchange side bit source
// ---------------------------------------------------------------
module balb_line_model
  import balb_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // stream content
  input wire logic bit_v,
  // line pins
  output logic rx_bit,
  output logic strobe,
  output logic frame_start
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div_r;
  logic [5:0] pos_r;
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_r <= 3'h0;
      pos_r <= 6'h00;
    end
    else if (div_r == 3'h5)
    begin
      div_r <= 3'h0;
      pos_r <= (pos_r == FRAME_LAST) ? 6'h00 : pos_r + 6'h01;
    end
    else
      div_r <= div_r + 3'h1;
  end
  // six cycles a bit keeps strobes well apart after the synchroniser
  assign strobe = arst_n && (div_r < 3'h2);
  assign frame_start = strobe && (pos_r == 6'h00);
  // outside its valid span the line shows the inverse, never a stale bit
  assign rx_bit = (div_r < 3'h4) ? bit_v : !bit_v;
endmodule

// ---- bench/balb_loopback_asserts.sv ----
module balb_loopback_asserts
  import balb_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // watched ports
  input wire logic line_active,
  input wire logic loop2_req,
  input wire logic line_tx_valid,
  input wire logic user_tx_valid,
  input wire logic user_tx_echo_zero,
  input wire logic user_tx_active_frame,
  input wire logic loop2_active,
  input wire logic loop3_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_loop_one_only: assert property (!(loop2_active && loop3_active)) else $error("both loops active");
  a_deact_clears: assert property ((!line_active) [*5] |-> !loop2_active && !loop3_active)
    else $error("loop kept after deactivation");
  a_echo_needs_loop: assert property (user_tx_echo_zero |-> loop2_active || $past(loop2_active))
    else $error("echo forced without loop 2");
  a_echo_in_frame: assert property (user_tx_echo_zero |-> user_tx_active_frame)
    else $error("echo forced without active frames");
  a_ret_one_pulse: assert property (line_tx_valid |=> !line_tx_valid) else $error("return valid too long");
  a_fwd_one_pulse: assert property (user_tx_valid |=> !user_tx_valid) else $error("forward valid too long");
  a_l3_yields: assert property ($rose(loop3_active) |-> !loop2_active) else $error("loop 3 over loop 2");
  a_l2_cause: assert property ($rose(loop2_active) |-> $past(loop2_req, 2)) else $error("loop 2 without request");
  a_rst_quiet: assert property ($rose(arst_n) |-> !loop2_active && !loop3_active)
    else $error("loop active at reset release");
endmodule
bind balb_loopback balb_loopback_asserts chk_u (.core_clk(core_clk), .arst_n(arst_n), .line_active(line_active),
  .loop2_req(loop2_req), .line_tx_valid(line_tx_valid), .user_tx_valid(user_tx_valid),
  .user_tx_echo_zero(user_tx_echo_zero), .user_tx_active_frame(user_tx_active_frame),
  .loop2_active(loop2_active), .loop3_active(loop3_active));

// ---- bench/balb_loopback_tb.sv ----
module balb_loopback_tb
  import balb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, arst_n = 1'b0, bit_v = 1'b1, line_active = 1'b0;
  logic loop2_req = 1'b0, loop2_tr = 1'b0, l3_tr = 1'b0, addressed = 1'b0;
  logic [5:0] ctl = 6'h00;
  logic [2:0] mask = 3'h7;
  logic [7:0] lxor = 8'h00;
  logic rx_bit, strobe, fstart, ltx, ltx_v, utx, utx_v, echo0, afr, l2a, l3a, tpat;
  int fails = 0, cmp_count = 0;
  initial
  begin
    forever #25 core_clk = !core_clk;
  end
  balb_line_model line_u (.core_clk(core_clk), .arst_n(arst_n), .bit_v(bit_v), .rx_bit(rx_bit),
    .strobe(strobe), .frame_start(fstart));
  // user return carries the inverse so any leak into the loop shows
  balb_loopback #(.DEPTH(4)) dut_u (.core_clk(core_clk), .arst_n(arst_n), .line_rx_bit(rx_bit),
    .line_rx_strobe(strobe), .line_rx_frame_start(fstart), .line_active(line_active), .line_tx_bit(ltx),
    .line_tx_valid(ltx_v), .user_tx_bit(utx), .user_tx_valid(utx_v), .user_tx_echo_zero(echo0),
    .user_tx_active_frame(afr), .user_rx_bit(!bit_v), .user_rx_valid(strobe), .loop2_req(loop2_req),
    .loop2_transparent(loop2_tr), .loop3_l3_on(ctl[0]), .loop3_l3_off(ctl[1]), .loop3_local_on(ctl[2]),
    .loop3_local_off(ctl[3]), .loop3_remote_on(ctl[4]), .loop3_remote_off(ctl[5]),
    .loop3_transparent(l3_tr), .loop3_addressed(addressed), .loop3_chan_mask(mask), .logical_xor(lxor),
    .loop2_active(l2a), .loop3_active(l3a), .test_pattern_bit(tpat));
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wait_for(input bit three, input logic lvl);
    int i;
    for (i = 0; i < 1000 && ((three ? l3a : l2a) !== lvl); i++)
      step(1);
    if (i == 1000)
    begin
      fails++;
      end_of_test();
    end
  endtask
  task automatic pulse(input int i);
    ctl[i] = 1'b1;
    step(1);
    ctl[i] = 1'b0;
  endtask
  // full loop 2, checked on both directions for a whole frame
  task automatic s_loop2(input logic tr, input logic v);
    bit_v = v;
    loop2_tr = tr;
    loop2_req = 1'b1;
    wait_for(0, 1'b1);
    step(300);
    chk("echo_zero", echo0, tr);
    chk("pattern_off", tpat, 1'b0);
    if (tr)
      chk("active_frame", afr, 1'b1);
    repeat (300)
    begin
      if (ltx_v === 1'b1)
        chk("line_tx_bit", ltx, v);
      if (utx_v === 1'b1)
        chk("user_tx_bit", utx, tr ? v : FWD_IDLE_BIT);
      step(1);
    end
    loop2_req = 1'b0;
    wait_for(0, 1'b0);
  endtask
  // partial loop 3 over b1 and b2 with xor 8'h0f: 16 bits a frame return, 8 of them inverted
  task automatic s_l3_data();
    int n_ret = 0;
    int n_inv = 0;
    int n_idle = 0;
    int n_pat = 0;
    step(300);
    repeat (288)
    begin
      if (ltx_v === 1'b1)
      begin
        n_ret++;
        if (ltx !== bit_v)
          n_inv++;
      end
      if (utx_v === 1'b1 && utx !== FWD_IDLE_BIT)
        n_idle++;
      if (tpat === 1'b1)
        n_pat++;
      step(1);
    end
    chk("l3_returned", 16'(n_ret), 16'h0010);
    chk("l3_modified", 16'(n_inv), 16'h0008);
    chk("l3_fwd_idle", 16'(n_idle), 16'h0000);
    chk("l3_pattern", 16'(n_pat != 0), 16'h0001);
  endtask
  task automatic s_loop3();
    addressed = 1'b0;
    mask = 3'h3;
    lxor = 8'h0f;
    pulse(0);
    step(700);
    chk("l3_unaddressed", l3a, 1'b0);
    pulse(2);
    wait_for(1, 1'b1);
    pulse(3);
    wait_for(1, 1'b0);
    addressed = 1'b1;
    pulse(4);
    wait_for(1, 1'b1);
    s_l3_data();
    loop2_req = 1'b1;
    wait_for(0, 1'b1);
    chk("l3_overridden", l3a, 1'b0);
    loop2_req = 1'b0;
    pulse(5);
    wait_for(0, 1'b0);
    chk("l3_remote_off", l3a, 1'b0);
    l3_tr = 1'b1;
    pulse(0);
    wait_for(1, 1'b1);
    repeat (60)
    begin
      if (utx_v === 1'b1)
        chk("l3_fwd_bit", utx, bit_v);
      step(1);
    end
    chk("l3_active_frame", afr, 1'b1);
    line_active = 1'b0;
    step(8);
    chk("l3_deact", l3a, 1'b0);
    line_active = 1'b1;
    pulse(1);
  endtask
  initial
  begin
    step(10);
    arst_n = 1'b1;
    line_active = 1'b1;
    step(4);
    s_loop2(1'b1, 1'b1);
    s_loop2(1'b1, 1'b0);
    s_loop2(1'b0, 1'b0);
    s_loop3();
    end_of_test();
  end
endmodule
